// ==== core/crs_pkg.sv ====
// Constants, enumerations and carrier structs for the core register,
// stack and interrupt block. Shared by the design and its bench.
package crs_pkg;

    localparam int NUM_IRQ = 8;
    localparam logic [15:0] DS_GPR_LAST = 16'h001f;
    localparam logic [15:0] DS_IO_BASE = 16'h0020;
    localparam logic [5:0] IO_STACK_LOW = 6'h3d;
    localparam logic [5:0] IO_STACK_HIGH = 6'h3e;
    localparam logic [15:0] TOP_OF_RAM = 16'h04ff;
    localparam logic HAS_STACK_HIGH = 1'b1;
    localparam logic [4:0] PTR_BASE_REG = 5'h1a;
    localparam logic [7:0] IRQ_LEVEL_MASK = 8'h80;
    localparam logic [15:0] VEC_STEP = 16'h0001;
    localparam logic [2:0] ENTRY_CYCLES = 3'h4;
    localparam logic [2:0] WAKE_CYCLES = 3'h4;
    localparam logic [2:0] RETURN_CYCLES = 3'h2;

    typedef enum logic [1:0] {
        PTR_NONE = 2'b00,
        PTR_DISP = 2'b01,
        PTR_POSTINC = 2'b10,
        PTR_PREDEC = 2'b11
    } crs_ptr_mode_e;

    typedef enum logic [2:0] {
        STK_NONE = 3'b000,
        STK_PUSH1 = 3'b001,
        STK_POP1 = 3'b010,
        STK_PUSH2 = 3'b011,
        STK_POP2 = 3'b100
    } crs_stk_op_e;

    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_WAKE = 2'b01,
        ST_ENTRY = 2'b10,
        ST_RETURN = 2'b11
    } crs_state_e;

    typedef struct packed {
        logic [4:0] rd_a;
        logic [4:0] rd_b;
        logic wr_en;
        logic wr_wide;
        logic [4:0] wr_addr;
        logic [15:0] wr_data;
    } crs_rf_req_s;

    typedef struct packed {
        logic go;
        logic [1:0] sel;
        crs_ptr_mode_e mode;
        logic [5:0] disp;
    } crs_ptr_req_s;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [7:0] wdata;
    } crs_ds_req_s;

    typedef struct packed {
        logic [7:0] evt;
        logic [7:0] level;
        logic [7:0] enable;
        logic [7:0] clear;
    } crs_irq_in_s;

    typedef struct packed {
        logic instr_done;
        logic jump;
        logic [15:0] jump_pc;
        logic unmask_all_int;
        logic mask_all_int;
        logic handler_exit;
        logic [15:0] handler_exit_pc;
        logic core_flags_register_wr;
        logic core_flags_register_i;
        logic sleeping;
        crs_stk_op_e stk_op;
        logic vec_move;
        logic [7:0] vec_base;
    } crs_ctl_s;

endpackage

// ==== core/crs_core_regs.sv ====
// Register file, pointer pairs, stack pointer, fetch stage and interrupt acceptance.
// Assumes a combinational program memory and an executing datapath on clk_sys.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Register file offers 8/8, 2x8/8, 2x8/16 and 16/16 read/write combinations.
// - The 32 registers also answer at data addresses 0x00 to 0x1F.
// - Registers 26..31 pair into three 16-bit pointers, even register low.
// - Pointers support displacement, post-increment and pre-decrement addressing.
// - Stack pointer sits at I/O 0x3E/0x3D and resets to top of RAM.
// - The stack grows toward lower addresses.
// - Stack moves one per byte, two per call, interrupt or return.
// - Small data spaces may drop the stack high byte.
// - Fetch overlaps execute, one instruction per clock.
// - Two operands read, computed and written back in one clock.
// - Each source has its own vector; lower vector means higher priority.
// - Acceptance needs both the source enable and global enable.
// - Vector table relocates to a 256-byte aligned base.
// - Acceptance clears global enable; handlers may set it to nest.
// - Handler exit sets global enable again.
// - Events set a flag; acceptance or writing one clears it.
// - Flags still set while disabled and are serviced once enabled.
// - Flags gathered while globally disabled are served in priority order.
// - Level sources have no flag and request only while present.
// - One main instruction runs after handler exit before another interrupt.
// - Global disable blocks acceptance at once, same cycle included.
// - Entry takes four clocks, pushes the return address, then jumps.
// - Waking from sleep adds four clocks before entry.
// - Handler exit takes two clocks, restores PC, adds two to stack.
// - One instruction runs after global enable before any interrupt.
module crs_core_regs
    import crs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire crs_rf_req_s rf_req,
    output logic [7:0] rd_a_data,
    output logic [7:0] rd_b_data,
    output logic [15:0] rd_w_data,
    input wire crs_ptr_req_s ptr_req,
    output logic [15:0] ptr_addr,
    input wire crs_ds_req_s ds_req,
    output logic [7:0] ds_rdata,
    input wire crs_ctl_s ctl,
    input wire crs_irq_in_s irq,
    input wire logic [15:0] pm_data,
    output logic [15:0] pm_addr,
    output logic [15:0] instr,
    output logic instr_valid,
    output logic [15:0] stack_top_pointer,
    output logic global_enable,
    output logic [7:0] irq_flags,
    output logic stk_wr,
    output logic [15:0] stk_addr,
    output logic [7:0] stk_wdata,
    output logic irq_ack,
    output logic [2:0] irq_ack_index
);

    function automatic logic [15:0] pair_of(input logic [7:0] lo, input logic [7:0] hi);
        return {hi, lo};
    endfunction

    function automatic logic [2:0] first_set(input logic [7:0] v);
        logic [2:0] r;
        r = 3'h0;
        for (int i = NUM_IRQ - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction

    function automatic logic [15:0] vector_of(input logic [2:0] idx, input logic mv, input logic [7:0] base);
        logic [15:0] b;
        b = mv ? {1'b0, base, 7'h00} : 16'h0000;
        return b + ((16'(idx) + 16'h0001) * VEC_STEP);
    endfunction

    logic [7:0] gpr_q [32];
    logic [15:0] sp_q;
    logic [15:0] pc_q;
    logic [15:0] ir_q;
    logic ir_valid_q;
    logic gie_q;
    logic [7:0] flags_q;
    crs_state_e st_q;
    logic [2:0] cnt_q;
    logic [15:0] save_pc_q;
    logic [2:0] sel_q;
    logic [7:0] ds_rdata_q;
    logic stk_wr_q;
    logic [15:0] stk_addr_q;
    logic [7:0] stk_wdata_q;
    logic ack_q;
    logic [2:0] ack_idx_q;

    // Pointer pair: X, Y, Z at 26, 28, 30
    logic [4:0] ptr_lo;
    logic [15:0] ptr_base;
    logic [15:0] ptr_next;
    assign ptr_lo = PTR_BASE_REG + {2'b00, ptr_req.sel, 1'b0};
    assign ptr_base = pair_of(gpr_q[ptr_lo], gpr_q[ptr_lo + 5'h01]);

    always_comb begin
        unique case (ptr_req.mode)
            PTR_DISP: begin
                ptr_addr = ptr_base + {10'h000, ptr_req.disp};
                ptr_next = ptr_base;
            end
            PTR_POSTINC: begin
                ptr_addr = ptr_base;
                ptr_next = ptr_base + 16'h0001;
            end
            PTR_PREDEC: begin
                ptr_addr = ptr_base - 16'h0001;
                ptr_next = ptr_base - 16'h0001;
            end
            PTR_NONE: begin
                ptr_addr = ptr_base;
                ptr_next = ptr_base;
            end
        endcase
    end

    // Reads are combinational so the datapath can compute and write back in one clock
    assign rd_a_data = gpr_q[rf_req.rd_a];
    assign rd_b_data = gpr_q[rf_req.rd_b];
    assign rd_w_data = pair_of(gpr_q[{rf_req.rd_a[4:1], 1'b0}], gpr_q[{rf_req.rd_a[4:1], 1'b1}]);

    logic ds_gpr;
    logic ds_spl;
    logic ds_sph;
    assign ds_gpr = ds_req.addr <= DS_GPR_LAST;
    assign ds_spl = ds_req.addr == (DS_IO_BASE + {10'h000, IO_STACK_LOW});
    assign ds_sph = HAS_STACK_HIGH && ds_req.addr == (DS_IO_BASE + {10'h000, IO_STACK_HIGH});

    // Later writes in this block win: pointer update over datapath write
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            for (int i = 0; i < 32; i++) begin
                gpr_q[i] <= 8'h00;
            end
        end else begin
            if (rf_req.wr_en && rf_req.wr_wide) begin
                gpr_q[{rf_req.wr_addr[4:1], 1'b0}] <= rf_req.wr_data[7:0];
                gpr_q[{rf_req.wr_addr[4:1], 1'b1}] <= rf_req.wr_data[15:8];
            end else if (rf_req.wr_en) begin
                gpr_q[rf_req.wr_addr] <= rf_req.wr_data[7:0];
            end
            if (ds_req.wr && ds_gpr) begin
                gpr_q[ds_req.addr[4:0]] <= ds_req.wdata;
            end
            if (ptr_req.go && (ptr_req.mode == PTR_POSTINC || ptr_req.mode == PTR_PREDEC)) begin
                gpr_q[ptr_lo] <= ptr_next[7:0];
                gpr_q[ptr_lo + 5'h01] <= ptr_next[15:8];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ds_rdata_q <= 8'h00;
        end else if (ds_req.rd) begin
            ds_rdata_q <= ds_gpr ? gpr_q[ds_req.addr[4:0]] :
                ds_spl ? sp_q[7:0] : ds_sph ? sp_q[15:8] : 8'h00;
        end
    end

    // Interrupt request evaluation
    logic [7:0] pending;
    logic [2:0] win;
    logic boundary;
    logic take;
    assign pending = ((flags_q & ~IRQ_LEVEL_MASK) | (irq.level & IRQ_LEVEL_MASK)) & irq.enable;
    assign win = first_set(pending);
    // A bubble after any jump or return is not a boundary, so one real instruction runs first
    assign boundary = ir_valid_q && ctl.instr_done && !ctl.handler_exit;
    assign take = st_q == ST_RUN && gie_q && !ctl.mask_all_int && (|pending) && (boundary || ctl.sleeping);

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            flags_q <= 8'h00;
        end else begin
            // Set after clear so an event in the clearing cycle survives
            flags_q <= (flags_q & ~irq.clear & ~(take ? (8'h01 << win) : 8'h00))
                | (irq.evt & ~IRQ_LEVEL_MASK);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            gie_q <= 1'b0;
        end else if (take) begin
            gie_q <= 1'b0;
        end else if (ctl.mask_all_int) begin
            gie_q <= 1'b0;
        end else if (ctl.unmask_all_int) begin
            gie_q <= 1'b1;
        end else if (ctl.core_flags_register_wr) begin
            gie_q <= ctl.core_flags_register_i;
        end else if (st_q == ST_RETURN && cnt_q == RETURN_CYCLES - 3'h1) begin
            gie_q <= 1'b1;
        end
    end

    // Sequencer and fetch stage; status flags are never pushed here
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st_q <= ST_RUN;
            cnt_q <= 3'h0;
            pc_q <= 16'h0000;
            ir_q <= 16'h0000;
            ir_valid_q <= 1'b0;
            save_pc_q <= 16'h0000;
            sel_q <= 3'h0;
            ack_q <= 1'b0;
            ack_idx_q <= 3'h0;
        end else begin
            ack_q <= 1'b0;
            unique case (st_q)
                ST_RUN: begin
                    cnt_q <= 3'h0;
                    if (take) begin
                        sel_q <= win;
                        save_pc_q <= ctl.jump ? ctl.jump_pc : pc_q;
                        ir_valid_q <= 1'b0;
                        st_q <= ctl.sleeping ? ST_WAKE : ST_ENTRY;
                    end else if (boundary && ctl.jump) begin
                        pc_q <= ctl.jump_pc;
                        ir_valid_q <= 1'b0;
                    end else if (ir_valid_q && ctl.instr_done && ctl.handler_exit) begin
                        save_pc_q <= ctl.handler_exit_pc;
                        ir_valid_q <= 1'b0;
                        st_q <= ST_RETURN;
                    end else if (!ir_valid_q || ctl.instr_done) begin
                        ir_q <= pm_data;
                        ir_valid_q <= !ctl.sleeping;
                        pc_q <= ctl.sleeping ? pc_q : pc_q + 16'h0001;
                    end
                end
                ST_WAKE: begin
                    cnt_q <= cnt_q + 3'h1;
                    if (cnt_q == WAKE_CYCLES - 3'h1) begin
                        cnt_q <= 3'h0;
                        st_q <= ST_ENTRY;
                    end
                end
                ST_ENTRY: begin
                    cnt_q <= cnt_q + 3'h1;
                    if (cnt_q == ENTRY_CYCLES - 3'h1) begin
                        pc_q <= vector_of(sel_q, ctl.vec_move, ctl.vec_base);
                        ack_q <= 1'b1;
                        ack_idx_q <= sel_q;
                        st_q <= ST_RUN;
                    end
                end
                ST_RETURN: begin
                    cnt_q <= cnt_q + 3'h1;
                    if (cnt_q == RETURN_CYCLES - 3'h1) begin
                        pc_q <= save_pc_q;
                        st_q <= ST_RUN;
                    end
                end
            endcase
        end
    end

    // Stack pointer and return-address pushes
    logic [15:0] sp_mask;
    assign sp_mask = HAS_STACK_HIGH ? 16'hffff : 16'h00ff;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sp_q <= TOP_OF_RAM & sp_mask;
            stk_wr_q <= 1'b0;
            stk_addr_q <= 16'h0000;
            stk_wdata_q <= 8'h00;
        end else begin
            stk_wr_q <= 1'b0;
            if (st_q == ST_ENTRY && cnt_q < 3'h2) begin
                stk_wr_q <= 1'b1;
                stk_addr_q <= sp_q;
                stk_wdata_q <= cnt_q == 3'h0 ? save_pc_q[7:0] : save_pc_q[15:8];
                sp_q <= (sp_q - 16'h0001) & sp_mask;
            end else if (st_q == ST_RETURN && cnt_q == 3'h0) begin
                sp_q <= (sp_q + 16'h0002) & sp_mask;
            end else if (ds_req.wr && ds_spl) begin
                sp_q <= {sp_q[15:8], ds_req.wdata};
            end else if (ds_req.wr && ds_sph) begin
                sp_q <= {ds_req.wdata, sp_q[7:0]};
            end else if (st_q == ST_RUN) begin
                unique case (ctl.stk_op)
                    STK_PUSH1: sp_q <= (sp_q - 16'h0001) & sp_mask;
                    STK_POP1: sp_q <= (sp_q + 16'h0001) & sp_mask;
                    STK_PUSH2: sp_q <= (sp_q - 16'h0002) & sp_mask;
                    STK_POP2: sp_q <= (sp_q + 16'h0002) & sp_mask;
                    STK_NONE: sp_q <= sp_q;
                    default: sp_q <= sp_q;
                endcase
            end
        end
    end

    assign pm_addr = pc_q;
    assign instr = ir_q;
    assign instr_valid = ir_valid_q;
    assign stack_top_pointer = sp_q;
    assign global_enable = gie_q;
    assign irq_flags = flags_q;
    assign ds_rdata = ds_rdata_q;
    assign stk_wr = stk_wr_q;
    assign stk_addr = stk_addr_q;
    assign stk_wdata = stk_wdata_q;
    assign irq_ack = ack_q;
    assign irq_ack_index = ack_idx_q;

    sequence s_entry;
        (st_q == ST_ENTRY) [*4] ##1 st_q == ST_RUN;
    endsequence
    sequence s_wake;
        (st_q == ST_WAKE) [*4];
    endsequence
    property p_entry_len;
        @(posedge clk_sys) disable iff (reset) take && !ctl.sleeping |=> s_entry;
    endproperty
    a_entry_len: assert property (p_entry_len) else $error("entry not four cycles");
    property p_wake_len;
        @(posedge clk_sys) disable iff (reset) take && ctl.sleeping |=> s_wake ##1 s_entry;
    endproperty
    a_wake_len: assert property (p_wake_len) else $error("wake entry not eight cycles");
    property p_gie_cleared;
        @(posedge clk_sys) disable iff (reset) take |=> !gie_q [*4];
    endproperty
    a_gie_cleared: assert property (p_gie_cleared) else $error("global enable not cleared on entry");
    // A handler exit in the disable cycle is legal, so only entry states are forbidden
    property p_cli_blocks;
        @(posedge clk_sys) disable iff (reset) ctl.mask_all_int && st_q == ST_RUN |=> st_q != ST_ENTRY && st_q != ST_WAKE;
    endproperty
    a_cli_blocks: assert property (p_cli_blocks) else $error("interrupt taken despite disable");
    property p_needs_gie;
        @(posedge clk_sys) disable iff (reset) !gie_q && st_q == ST_RUN |=> st_q == ST_RUN || st_q == ST_RETURN;
    endproperty
    a_needs_gie: assert property (p_needs_gie) else $error("interrupt taken without global enable");
    property p_return;
        @(posedge clk_sys) disable iff (reset)
            st_q == ST_RUN && ir_valid_q && ctl.instr_done && ctl.handler_exit && !take
            |=> (st_q == ST_RETURN) [*2] ##1 gie_q && sp_q == (($past(sp_q, 2) + 16'h0002) & sp_mask);
    endproperty
    a_return: assert property (p_return) else $error("handler exit sequence wrong");
    property p_vector;
        @(posedge clk_sys) disable iff (reset) ack_q |-> pc_q == vector_of(ack_idx_q, ctl.vec_move, ctl.vec_base);
    endproperty
    a_vector: assert property (p_vector) else $error("wrong vector loaded");
    property p_no_level_flag;
        @(posedge clk_sys) disable iff (reset) (flags_q & IRQ_LEVEL_MASK) == 8'h00;
    endproperty
    a_no_level_flag: assert property (p_no_level_flag) else $error("level source has a flag");
    property p_event_flag;
        @(posedge clk_sys) disable iff (reset) (irq.evt & ~IRQ_LEVEL_MASK) != 8'h00
            |=> (flags_q & $past(irq.evt & ~IRQ_LEVEL_MASK)) == $past(irq.evt & ~IRQ_LEVEL_MASK);
    endproperty
    a_event_flag: assert property (p_event_flag) else $error("event lost");
endmodule // crs_core_regs

`default_nettype wire

// ==== tb/crs_far_model.sv ====
// Far-side model: combinational program memory and peripheral event sources.
// Assumes the bench raises fire bits shortly after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module crs_far_model (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [15:0] pm_addr,
    output logic [15:0] pm_data,
    input wire logic [7:0] fire,
    output logic [7:0] evt
);
    logic [7:0] fire_q;
    // Every address gives a different word, so a stale fetch cannot pass
    assign pm_data = {pm_addr[7:0] ^ 8'h5c, pm_addr[15:8] + 8'h31};
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            fire_q <= 8'h00;
            evt <= 8'h00;
        end else begin
            fire_q <= fire;
            // Sources give one pulse per rise, never a level
            evt <= fire & ~fire_q;
        end
    end
endmodule // crs_far_model
`default_nettype wire

// ==== tb/crs_core_regs_tb.sv ====
// Self-checking bench for crs_core_regs: registers, pointers, stack, fetch, interrupts.
// Assumes crs_far_model supplies program words and event pulses.
`timescale 1ns/1ps
`default_nettype none
module crs_core_regs_tb;
    import crs_pkg::*;
    logic clk_sys;
    logic reset;
    crs_rf_req_s rf_req;
    crs_ptr_req_s ptr_req;
    crs_ds_req_s ds_req;
    crs_ctl_s ctl;
    crs_irq_in_s irq;
    crs_irq_in_s irq_in;
    logic [7:0] fire, evt_w, rd_a_data, rd_b_data, ds_rdata, irq_flags, stk_wdata;
    logic [15:0] rd_w_data, ptr_addr, pm_data, pm_addr, instr, stack_top_pointer, stk_addr;
    logic instr_valid, global_enable, stk_wr, irq_ack;
    logic [2:0] irq_ack_index;
    int n_mismatch = 0;
    int num_checks = 0;
    int n_push = 0;
    int n_ack = 0;
    logic [47:0] push_log = '0;
    int cyc = 0;
    crs_stk_op_e ops[4] = '{STK_PUSH1, STK_POP1, STK_PUSH2, STK_POP2};
    logic [15:0] dl[4] = '{16'hffff, 16'h0001, 16'hfffe, 16'h0002};

    assign irq_in = {evt_w, irq.level, irq.enable, irq.clear};

    crs_core_regs dut_u (.clk_sys(clk_sys), .reset(reset), .rf_req(rf_req), .rd_a_data(rd_a_data),
        .rd_b_data(rd_b_data), .rd_w_data(rd_w_data), .ptr_req(ptr_req), .ptr_addr(ptr_addr),
        .ds_req(ds_req), .ds_rdata(ds_rdata), .ctl(ctl), .irq(irq_in), .pm_data(pm_data),
        .pm_addr(pm_addr), .instr(instr), .instr_valid(instr_valid),
        .stack_top_pointer(stack_top_pointer), .global_enable(global_enable), .irq_flags(irq_flags),
        .stk_wr(stk_wr), .stk_addr(stk_addr), .stk_wdata(stk_wdata), .irq_ack(irq_ack),
        .irq_ack_index(irq_ack_index));

    crs_far_model far_u (.clk_sys(clk_sys), .reset(reset), .pm_addr(pm_addr), .pm_data(pm_data),
        .fire(fire), .evt(evt_w));

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (stk_wr === 1'b1) begin
            n_push <= n_push + 1;
            push_log <= {push_log[23:0], stk_addr, stk_wdata};
        end
        if (irq_ack === 1'b1) n_ack <= n_ack + 1;
        // Whole run needs well under a thousand cycles
        if (cyc == 5000) begin
            n_mismatch++;
            summarize();
        end
    end

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    function automatic logic [15:0] word(input logic [15:0] a);
        return {a[7:0] ^ 8'h5c, a[15:8] + 8'h31};
    endfunction

    task automatic tick(input int n = 1);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            n_mismatch++;
        end
    endtask

    task automatic rf_wr(input logic [4:0] a, input logic [15:0] d, input logic wide);
        rf_req.wr_en = 1'b1;
        rf_req.wr_wide = wide;
        rf_req.wr_addr = a;
        rf_req.wr_data = d;
        tick();
        rf_req.wr_en = 1'b0;
        // An idle edge keeps a following call from lowering and raising the strobe in one step
        tick();
    endtask

    task automatic ds_wr(input logic [15:0] a, input logic [7:0] d);
        ds_req.wr = 1'b1;
        ds_req.addr = a;
        ds_req.wdata = d;
        tick();
        ds_req.wr = 1'b0;
        tick();
    endtask

    task automatic ds_rd(input logic [15:0] a, input logic [7:0] exp);
        ds_req.rd = 1'b1;
        ds_req.addr = a;
        tick();
        ds_req.rd = 1'b0;
        check({8'h00, ds_rdata}, {8'h00, exp});
        tick();
    endtask

    task automatic stk(input crs_stk_op_e op, input logic [15:0] delta);
        logic [15:0] sp;
        sp = stack_top_pointer;
        ctl.stk_op = op;
        tick();
        ctl.stk_op = STK_NONE;
        check(stack_top_pointer, sp + delta);
        tick();
    endtask

    // Sets global enable, waits for entry, runs a short handler and exits
    task automatic take_irq(input logic [2:0] idx, input logic slp, input logic [15:0] base);
        logic [15:0] sp;
        logic [7:0] en;
        logic [15:0] pc;
        int k;
        sp = stack_top_pointer;
        ctl.unmask_all_int = 1'b1;
        tick();
        ctl.unmask_all_int = 1'b0;
        ctl.sleeping = slp;
        check({15'h0, global_enable}, 16'h0001);
        k = 0;
        while (global_enable !== 1'b0 && k < 20) begin
            pc = pm_addr;
            tick();
            k++;
        end
        n_push = 0;
        k = 0;
        while (irq_ack !== 1'b1 && k < 20) begin
            tick();
            k++;
        end
        check(k[15:0], slp ? 16'h0008 : 16'h0004);
        check({13'h0, irq_ack_index}, {13'h0, idx});
        check(pm_addr, base + ({13'h0, idx} + 16'h0001) * VEC_STEP);
        check(n_push[15:0], 16'h0002);
        check(push_log[47:32], sp);
        check(push_log[23:8], sp - 16'h0001);
        check({push_log[7:0], push_log[31:24]}, pc);
        check({15'h0, instr_valid}, 16'h0000);
        check(stack_top_pointer, sp - 16'h0002);
        check({15'h0, global_enable}, 16'h0000);
        ctl.sleeping = 1'b0;
        en = irq.enable;
        irq.enable = 8'h00;
        tick(2);
        // Handler leaves the status flags to software
        ctl.handler_exit = 1'b1;
        ctl.handler_exit_pc = 16'h0040;
        tick();
        ctl.handler_exit = 1'b0;
        tick(2);
        check({15'h0, global_enable}, 16'h0001);
        check(stack_top_pointer, sp);
        check(pm_addr, 16'h0040);
        ctl.mask_all_int = 1'b1;
        tick();
        ctl.mask_all_int = 1'b0;
        irq.enable = en;
    endtask

    initial begin
        logic [15:0] a;
        reset = 1'b1;
        rf_req = '0;
        ptr_req = '0;
        ds_req = '0;
        ctl = '0;
        ctl.instr_done = 1'b1;
        irq = '0;
        fire = 8'h00;
        repeat (6) @(posedge clk_sys);
        #1;
        reset = 1'b0;
        check(stack_top_pointer, TOP_OF_RAM);
        check({7'h0, global_enable, irq_flags}, 16'h0000);
        ds_rd(16'h005d, TOP_OF_RAM[7:0]);
        ds_rd(16'h005e, TOP_OF_RAM[15:8]);
        ds_rd(16'h0070, 8'h00);
        a = pm_addr;
        tick();
        check(pm_addr, a + 16'h0001);
        check(instr, word(a));
        check({15'h0, instr_valid}, 16'h0001);
        rf_wr(5'd3, 16'h005a, 1'b0);
        rf_wr(5'd4, 16'h00c7, 1'b0);
        rf_req.rd_a = 5'd3;
        rf_req.rd_b = 5'd4;
        rf_wr(5'd5, 16'h0021, 1'b0);
        check({rd_a_data, rd_b_data}, 16'h5ac7);
        rf_req.rd_a = 5'd5;
        #1 check({8'h00, rd_a_data}, 16'h0021);
        rf_wr(5'd26, 16'h1234, 1'b1);
        rf_req.rd_a = 5'd26;
        rf_req.rd_b = 5'd27;
        #1 check(rd_w_data, 16'h1234);
        check({8'h00, rd_b_data}, 16'h0012);
        ds_rd(16'h001a, 8'h34);
        ds_wr(16'h001f, 8'ha5);
        rf_req.rd_b = 5'd31;
        #1 check({8'h00, rd_b_data}, 16'h00a5);
        ptr_req.sel = 2'd0;
        ptr_req.mode = PTR_DISP;
        ptr_req.disp = 6'h05;
        #1 check(ptr_addr, 16'h1239);
        ptr_req.mode = PTR_PREDEC;
        #1 check(ptr_addr, 16'h1233);
        ptr_req.mode = PTR_POSTINC;
        ptr_req.go = 1'b1;
        #1 check(ptr_addr, 16'h1234);
        tick();
        ptr_req.mode = PTR_PREDEC;
        check(rd_w_data, 16'h1235);
        tick();
        ptr_req.go = 1'b0;
        ptr_req.mode = PTR_NONE;
        check(rd_w_data, 16'h1234);
        for (int i = 0; i < 4; i++) stk(ops[i], dl[i]);
        ds_wr(16'h005d, 8'h10);
        ds_wr(16'h005e, 8'h03);
        check(stack_top_pointer, 16'h0310);
        fire = 8'h0e;
        tick();
        fire = 8'h00;
        tick(2);
        check({8'h00, irq_flags}, 16'h000e);
        irq.clear = 8'h08;
        tick();
        irq.clear = 8'h00;
        tick();
        check({8'h00, irq_flags}, 16'h0006);
        irq.enable = 8'h06;
        n_ack = 0;
        tick(6);
        check(n_ack[15:0], 16'h0000);
        take_irq(3'd1, 1'b0, 16'h0000);
        check({8'h00, irq_flags}, 16'h0004);
        irq.level = 8'h80;
        tick(2);
        irq.level = 8'h00;
        irq.enable = 8'h84;
        ctl.vec_move = 1'b1;
        ctl.vec_base = 8'h02;
        take_irq(3'd2, 1'b1, 16'h0100);
        ctl.unmask_all_int = 1'b1;
        tick();
        ctl.unmask_all_int = 1'b0;
        n_ack = 0;
        tick(8);
        check(n_ack[15:0], 16'h0000);
        check({8'h00, irq_flags}, 16'h0000);
        ctl.mask_all_int = 1'b1;
        tick();
        ctl.mask_all_int = 1'b0;
        irq.level = 8'h80;
        ctl.unmask_all_int = 1'b1;
        tick();
        ctl.unmask_all_int = 1'b0;
        ctl.mask_all_int = 1'b1;
        n_ack = 0;
        tick();
        ctl.mask_all_int = 1'b0;
        tick(8);
        check({n_ack[14:0], global_enable}, 16'h0000);
        take_irq(3'd7, 1'b0, 16'h0100);
        irq.level = 8'h00;
        summarize();
    end
endmodule // crs_core_regs_tb
`default_nettype wire
